// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
  import tscc_pkg::*;
  logic clk, nrst, wr, rd, ext, go, mc, irq;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, cbc, cba, cbb, cac, caa, cab, r, c1, c2, t;
  logic [7:0] width;
  logic [1:0] pins;
  logic p[2];
  logic [31:0] seed;
  int mismatches, compares;
  ////////////////////////////////////////////////////////////////
  tscc_top i_dut (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CHAN_B_COUNTER(cbc), .CHAN_B_CONST_A(cba),
    .CHAN_B_CONST_B(cbb), .CHAN_A_COUNTER(cac), .CHAN_A_CONST_A(caa),
    .CHAN_A_CONST_B(cab), .EXT_RESET_IN_X(ext), .CHAN_B_OUT_PIN(pins[0]),
    .CHAN_A_OUT_PIN(pins[1]), .MATCH_C(mc), .CAPTURE_IRQ_REQUEST(irq));
  tscc_pulse i_src (.go(go), .width(width), .pin(ext));
  ////////////////////////////////////////////////////////////////
  function logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic exp_pin(input logic q, input logic [1:0] c);
    return (c == 2'h0) ? q : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? 1'b1 : ~q;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle equality pulse on a counter, then back to idle
  task hit(input int ch, input int cm);
    @(posedge clk);
    if (ch == 1) cac <= (cm == 1) ? caa : cab;
    else cbc <= (cm == 1) ? cba : cbb;
    @(posedge clk);
    cac <= 8'h40;
    cbc <= 8'h40;
  endtask
  task final_report;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // whole sequence is well under 2000 cycles
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
  initial begin
    seed = 32'h0000f456;
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; go = 1'b0; addr = 3'h0; wdata = 8'h00;
    width = 8'h10; cbc = 8'h40; cac = 8'h40; p[0] = 1'b0; p[1] = 1'b0;
    // consts above 0x7f with bit 1 clear: never the idle 0x40, never the wrap value ff
    cbb = (xs() | 8'h80) & 8'hfd;
    cba = cbb ^ 8'h01;
    cab = (xs() | 8'h80) & 8'hfd;
    caa = cab ^ 8'h01;
    cyc(2);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], r);
      chk("reset value", (a == 2) ? 8'hff : 8'h00, r);
    end
    for (int ch = 0; ch < 2; ch++) begin
      for (int cm = 0; cm < 2; cm++) begin
        for (int c = 0; c < 4; c++) begin
          wr_reg(ch[2:0], 8'(c << ((cm == 1) ? 0 : 2)));
          hit(ch, cm);
          cyc(3);
          p[ch] = exp_pin(p[ch], c[1:0]);
          chk("out pin", {7'h0, p[ch]}, {7'h0, pins[ch]});
        end
      end
    end
    wr_reg(3'h0, 8'h00);
    rd_reg(3'h0, r);
    chk("flags kept", 8'hc0, r & 8'he0);
    wr_reg(3'h0, 8'he0);
    rd_reg(3'h0, r);
    chk("ones ignored", 8'hc0, r & 8'he0);
    wr_reg(3'h0, 8'h00);
    rd_reg(3'h0, r);
    chk("flags cleared", 8'h00, r);
    rd_reg(3'h1, r);
    chk("chan a flags", 8'hc0, r & 8'he0);
    @(posedge clk) cbc <= 8'hff;
    @(posedge clk) cbc <= 8'h00;
    @(posedge clk) cbc <= 8'h40;
    rd_reg(3'h0, r);
    chk("wrap flag", 8'h20, r & 8'he0);
    // a write to register 5 disarms the read of zero left by the reset sweep
    wr_reg(3'h5, 8'h00);
    // start written without the read of zero must not arm
    wr_reg(3'h5, 8'h10);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    cyc(24);
    rd_reg(3'h3, r);
    chk("unarmed capture", 8'h00, r);
    c1 = 8'hc0;
    c2 = xs();
    rd_reg(3'h5, r);
    wr_reg(3'h5, 8'h10);
    rd_reg(3'h5, r);
    chk("start set", 8'h10, r & 8'h10);
    wr_reg(3'h0, 8'h10);
    @(posedge clk) cac <= c1;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    cyc(8);
    cac <= c2;
    cyc(16);
    cac <= 8'h40;
    rd_reg(3'h3, r);
    chk("rise capture", c1, r);
    rd_reg(3'h4, r);
    chk("fall capture", c2, r);
    rd_reg(3'h1, r);
    chk("capture flag", 8'h10, r & 8'h10);
    rd_reg(3'h5, r);
    chk("start cleared", 8'h00, r & 8'h10);
    chk("irq on", 8'h01, {7'h0, irq});
    wr_reg(3'h0, 8'h00);
    cyc(2);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr_reg(3'h3, 8'h55);
    rd_reg(3'h3, r);
    chk("capture read only", c1, r);
    t = xs() | 8'h80;
    wr_reg(3'h2, t);
    rd_reg(3'h2, r);
    chk("time constant", t, r);
    // sum overflows 8 bits on purpose
    @(posedge clk) cac <= t + c1;
    cyc(1);
    #1 chk("match c", 8'h01, {7'h0, mc});
    // rewrite of the constant blinds the compare for that cycle
    wr_reg(3'h2, t);
    #1 chk("match c blind", 8'h00, {7'h0, mc});
    @(posedge clk) cac <= 8'h40;
    cyc(1);
    #1 chk("match c off", 8'h00, {7'h0, mc});
    final_report;
  end
endmodule // tb

// ==== bench/tscc_pulse.sv ====
`timescale 1ns/10ps
// far-side pulse source on the external reset input
module tscc_pulse (
  input wire logic go,
  input wire logic [7:0] width,
  output logic pin
);
  initial begin
    pin = 1'b0;
  end
  // offset keeps edges away from the sampling clock
  always @(posedge go) begin
    #1.3 pin = 1'b1;
    repeat (width) #4;
    pin = 1'b0;
  end
endmodule // tscc_pulse

// ==== hdl/tscc_pin.sv ====
`timescale 1ns/10ps
module tscc_pin
  import tscc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ev_b,
  input wire logic ev_a,
  input wire logic [1:0] act_b,
  input wire logic [1:0] act_a,
  output logic pin
);
  tscc_pin_st_t st_ff;
  tscc_pin_st_t nxt_st;

  // a coincident compare-b action is applied last and so wins when it is high or low
  always_comb begin
    nxt_st = st_ff;
    if (ev_a) begin
      nxt_st.pin = tscc_act(nxt_st.pin, act_a);
    end
    if (ev_b) begin
      nxt_st.pin = tscc_act(nxt_st.pin, act_b);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin = st_ff.pin;
endmodule // tscc_pin

// ==== hdl/tscc_sync.sv ====
`timescale 1ns/10ps
module tscc_sync
  import tscc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic rise,
  output logic fall
);
  tscc_sync_st_t st_ff;
  tscc_sync_st_t nxt_st;

  // s1 feeds only s2; edges are taken between s2 and s3
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;
endmodule // tscc_sync

// ==== hdl/tscc_top.sv ====
`timescale 1ns/10ps
// What this block does
// - channel b counter equals const b sets flag
// - channel b counter equals const a sets flag
// - counter wrap from ff to 00 sets flag
// - flag clears only after read-one then write-zero
// - writing one to any flag is ignored
// - channel b bit 4 gates capture request
// - compare-b match drives channel b pin by bits 3:2
// - compare-a match drives channel b pin by bits 1:0
// - channel a compare matches set its flags
// - rise then fall on input sets capture flag
// - channel a matches drive channel a pin
// - counter equal to constant plus capture gives match c
// - match c suppressed on constant write, capture cycle
// - time constant readable, writable, resets to ff
// - capture registers read-only, eight bits, reset zero
// - start bit set: capture rise then fall
// - start bit self-clears after one measurement
// - both status registers reset to zero
// - start bit set by read-zero then write-one
module tscc_top
  import tscc_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [CW-1:0] CHAN_B_COUNTER,
  input wire logic [CW-1:0] CHAN_B_CONST_A,
  input wire logic [CW-1:0] CHAN_B_CONST_B,
  input wire logic [CW-1:0] CHAN_A_COUNTER,
  input wire logic [CW-1:0] CHAN_A_CONST_A,
  input wire logic [CW-1:0] CHAN_A_CONST_B,
  input wire logic EXT_RESET_IN_X,
  output logic CHAN_B_OUT_PIN,
  output logic CHAN_A_OUT_PIN,
  output logic MATCH_C,
  output logic CAPTURE_IRQ_REQUEST
);
  tscc_top_st_t st_ff;
  tscc_top_st_t nxt_st;
  logic ext_rise;
  logic ext_fall;
  logic wr_csb, wr_csa, wr_tcc, wr_conn;
  logic rd_csb, rd_csa, rd_conn;
  logic eq_bb, eq_ba, eq_ab, eq_aa, eq_c;
  logic wrap_b, wrap_a;
  logic cap_ld;
  logic [7:0] sum_c;
  logic [7:0] cs_b;
  logic [7:0] cs_a;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // set wins over the clear so an event in the clearing cycle survives
  function automatic logic flag_nxt(logic cur, logic set, logic arm, logic wr, logic wb);
    if (set) begin
      return 1'b1;
    end
    if (wr && arm && !wb) begin
      return 1'b0;
    end
    return cur;
  endfunction

  // armed by a read that saw one, consumed by the next write
  function automatic logic arm_nxt(logic arm, logic rd, logic cur, logic wr);
    if (wr) begin
      return 1'b0;
    end
    if (rd && cur) begin
      return 1'b1;
    end
    return arm;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin input and output pins

  tscc_sync u_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .din(EXT_RESET_IN_X),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  tscc_pin u_pin_b (
    .clk(CLK_SYS),
    .nrst(NRST),
    .ev_b(eq_bb && !st_ff.eq_prev[3]),
    .ev_a(eq_ba && !st_ff.eq_prev[2]),
    .act_b(st_ff.ctl_b[3:2]),
    .act_a(st_ff.ctl_b[1:0]),
    .pin(CHAN_B_OUT_PIN)
  );

  tscc_pin u_pin_a (
    .clk(CLK_SYS),
    .nrst(NRST),
    .ev_b(eq_ab && !st_ff.eq_prev[1]),
    .ev_a(eq_aa && !st_ff.eq_prev[0]),
    .act_b(st_ff.ctl_a[3:2]),
    .act_a(st_ff.ctl_a[1:0]),
    .pin(CHAN_A_OUT_PIN)
  );

  //////////////////////////////////////////////////////////////////////////
  // decode and compare

  assign wr_csb = WR && (ADDR == `TSCC_OFS_CS_B);
  assign wr_csa = WR && (ADDR == `TSCC_OFS_CS_A);
  assign wr_tcc = WR && (ADDR == `TSCC_OFS_TCC);
  assign wr_conn = WR && (ADDR == `TSCC_OFS_CONN);
  assign rd_csb = RD && (ADDR == `TSCC_OFS_CS_B);
  assign rd_csa = RD && (ADDR == `TSCC_OFS_CS_A);
  assign rd_conn = RD && (ADDR == `TSCC_OFS_CONN);

  assign eq_bb = (CHAN_B_COUNTER == CHAN_B_CONST_B);
  assign eq_ba = (CHAN_B_COUNTER == CHAN_B_CONST_A);
  assign eq_ab = (CHAN_A_COUNTER == CHAN_A_CONST_B);
  assign eq_aa = (CHAN_A_COUNTER == CHAN_A_CONST_A);
  assign wrap_b = (st_ff.prev_b == `TSCC_RST_CNT) && (CHAN_B_COUNTER == '0);
  assign wrap_a = (st_ff.prev_a == `TSCC_RST_CNT) && (CHAN_A_COUNTER == '0);

  // capture value is the rising-edge sample; the sum wraps in eight bits
  assign sum_c = 8'(st_ff.tcc + st_ff.rise);
  assign eq_c = (CHAN_A_COUNTER[7:0] == sum_c);
  assign cap_ld = (st_ff.cap == CAP_RISE && ext_rise) || (st_ff.cap == CAP_FALL && ext_fall);

  assign cs_b = {st_ff.flg_b, st_ff.ctl_b};
  assign cs_a = {st_ff.flg_a, st_ff.ctl_a};

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] set_a;
    logic [2:0] set_b;
    set_a = '0;
    set_b = '0;
    nxt_st = st_ff;
    nxt_st.prev_a = CHAN_A_COUNTER[7:0];
    nxt_st.prev_b = CHAN_B_COUNTER[7:0];
    nxt_st.eq_prev = {eq_bb, eq_ba, eq_ab, eq_aa};
    set_b = {eq_bb, eq_ba, wrap_b};
    set_a[3:1] = {eq_ab, eq_aa, wrap_a};

    // single-shot pulse width capture
    unique case (st_ff.cap)
      CAP_IDLE: begin
        if (st_ff.start) begin
          nxt_st.cap = CAP_RISE;
        end
      end
      CAP_RISE: begin
        if (ext_rise) begin
          nxt_st.rise = CHAN_A_COUNTER[7:0];
          nxt_st.cap = CAP_FALL;
        end
      end
      CAP_FALL: begin
        if (ext_fall) begin
          nxt_st.fall = CHAN_A_COUNTER[7:0];
          nxt_st.cap = CAP_IDLE;
          set_a[0] = 1'b1;
        end
      end
    endcase

    // flags: write of one ignored, clear needs a prior read of one
    for (int i = 0; i < 3; i++) begin
      nxt_st.flg_b[i] = flag_nxt(st_ff.flg_b[i], set_b[i], st_ff.arm_b[i], wr_csb,
                                 WDATA[5+i]);
      nxt_st.arm_b[i] = arm_nxt(st_ff.arm_b[i], rd_csb, st_ff.flg_b[i], wr_csb);
    end
    for (int i = 0; i < 4; i++) begin
      nxt_st.flg_a[i] = flag_nxt(st_ff.flg_a[i], set_a[i], st_ff.arm_a[i], wr_csa,
                                 WDATA[4+i]);
      nxt_st.arm_a[i] = arm_nxt(st_ff.arm_a[i], rd_csa, st_ff.flg_a[i], wr_csa);
    end
    if (wr_csb) begin
      nxt_st.ctl_b = WDATA[4:0];
    end
    if (wr_csa) begin
      nxt_st.ctl_a = WDATA[3:0];
    end
    if (wr_tcc) begin
      nxt_st.tcc = WDATA;
    end

    // start bit: armed by reading zero, set by writing one
    nxt_st.arm_start = rd_conn ? !st_ff.start : (wr_conn ? 1'b0 : st_ff.arm_start);
    if (wr_conn) begin
      if (WDATA[`TSCC_BIT_START] && st_ff.arm_start) begin
        nxt_st.start = 1'b1;
      end else if (!WDATA[`TSCC_BIT_START]) begin
        nxt_st.start = 1'b0;
        nxt_st.cap = CAP_IDLE;
      end
    end
    if (st_ff.cap == CAP_FALL && ext_fall) begin
      nxt_st.start = 1'b0;
    end

    // the compare is blind while either operand is being loaded
    nxt_st.match_c = eq_c && !wr_tcc && !cap_ld;
    nxt_st.irq = st_ff.ctl_b[`TSCC_BIT_B4] && st_ff.flg_a[0];

    // read data stands for one cycle only
    nxt_st.rdata = '0;
    if (RD) begin
      unique case (ADDR)
        `TSCC_OFS_CS_B: nxt_st.rdata = cs_b;
        `TSCC_OFS_CS_A: nxt_st.rdata = cs_a;
        `TSCC_OFS_TCC: nxt_st.rdata = st_ff.tcc;
        `TSCC_OFS_RISE: nxt_st.rdata = st_ff.rise;
        `TSCC_OFS_FALL: nxt_st.rdata = st_ff.fall;
        `TSCC_OFS_CONN: nxt_st.rdata = 8'(st_ff.start) << `TSCC_BIT_START;
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_ff <= '0;
      st_ff.tcc <= `TSCC_RST_TCC;
      st_ff.rise <= `TSCC_RST_CAP;
      st_ff.fall <= `TSCC_RST_CAP;
      st_ff.cap <= CAP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RDATA = st_ff.rdata;
  assign MATCH_C = st_ff.match_c;
  assign CAPTURE_IRQ_REQUEST = st_ff.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  match_b_flag_a: assert property (eq_bb |=> st_ff.flg_b[2])
    else $error("channel b match-b flag not set");
  match_a_flag_a: assert property (eq_ba |=> cs_b[`TSCC_BIT_MFA])
    else $error("channel b match-a flag not set");
  wrap_flag_a: assert property (wrap_a |=> cs_a[`TSCC_BIT_WRAP])
    else $error("channel a wrap flag not set");
  no_blind_clear_a: assert property (
    (wr_csb && !st_ff.arm_b[0] && st_ff.flg_b[0]) |=> st_ff.flg_b[0])
    else $error("wrap flag cleared without read");
  write_one_a: assert property (
    (wr_csa && !st_ff.flg_a[0] && !cap_ld) |=> !st_ff.flg_a[0])
    else $error("capture flag set by write");
  irq_gate_a: assert property (
    CAPTURE_IRQ_REQUEST == $past(st_ff.ctl_b[`TSCC_BIT_B4] && st_ff.flg_a[0], 1))
    else $error("capture request not gated");
  one_shot_a: assert property (
    (st_ff.cap == CAP_FALL && ext_fall) |=> (!st_ff.start && st_ff.flg_a[0]))
    else $error("start bit not cleared after capture");
  rise_cap_a: assert property (
    (st_ff.cap == CAP_RISE && ext_rise) |=> (st_ff.rise == $past(CHAN_A_COUNTER[7:0])))
    else $error("rising capture wrong");
  blind_c_a: assert property (wr_tcc |=> !MATCH_C)
    else $error("match c during constant write");
  sum_c_a: assert property (
    (eq_c && !wr_tcc && !cap_ld) |=> MATCH_C)
    else $error("match c missed");

  // pins: compare-b action goes last, so it decides a coincident match when it is high or low
  pin_b_high_a: assert property (
    (eq_bb && !st_ff.eq_prev[3] && st_ff.ctl_b[3:2] == `TSCC_ACT_HIGH) |=> CHAN_B_OUT_PIN)
    else $error("channel b pin not driven high");
  pin_b_low_a: assert property (
    (eq_bb && !st_ff.eq_prev[3] && st_ff.ctl_b[3:2] == `TSCC_ACT_LOW) |=> !CHAN_B_OUT_PIN)
    else $error("channel b pin not driven low");
  pin_b_tog_a: assert property (
    (eq_bb && !st_ff.eq_prev[3] && !(eq_ba && !st_ff.eq_prev[2]) &&
     st_ff.ctl_b[3:2] == `TSCC_ACT_TOG) |=> (CHAN_B_OUT_PIN != $past(CHAN_B_OUT_PIN)))
    else $error("channel b pin not toggled");
  pin_ba_high_a: assert property (
    (eq_ba && !st_ff.eq_prev[2] && !(eq_bb && !st_ff.eq_prev[3]) &&
     st_ff.ctl_b[1:0] == `TSCC_ACT_HIGH) |=> CHAN_B_OUT_PIN)
    else $error("channel b pin not driven high on match a");
  pin_b_hold_a: assert property (
    (!(eq_bb && !st_ff.eq_prev[3]) && !(eq_ba && !st_ff.eq_prev[2])) |=>
    $stable(CHAN_B_OUT_PIN))
    else $error("channel b pin moved without a match");
  pin_a_tog_a: assert property (
    (eq_ab && !st_ff.eq_prev[1] && !(eq_aa && !st_ff.eq_prev[0]) &&
     st_ff.ctl_a[3:2] == `TSCC_ACT_TOG) |=> (CHAN_A_OUT_PIN != $past(CHAN_A_OUT_PIN)))
    else $error("channel a pin not toggled");
  pin_a_low_a: assert property (
    (eq_aa && !st_ff.eq_prev[0] && !(eq_ab && !st_ff.eq_prev[1]) &&
     st_ff.ctl_a[1:0] == `TSCC_ACT_LOW) |=> !CHAN_A_OUT_PIN)
    else $error("channel a pin not driven low on match a");

  // flags and control
  wrap_b_a: assert property (wrap_b |=> cs_b[`TSCC_BIT_WRAP])
    else $error("channel b wrap flag not set");
  match_ab_a: assert property (eq_ab |=> cs_a[`TSCC_BIT_MFB])
    else $error("channel a match-b flag not set");
  match_aa_a: assert property (eq_aa |=> cs_a[`TSCC_BIT_MFA])
    else $error("channel a match-a flag not set");
  flag_clear_a: assert property (
    (wr_csb && st_ff.arm_b[2] && !WDATA[`TSCC_BIT_MFB] && !eq_bb) |=> !st_ff.flg_b[2])
    else $error("armed flag not cleared by zero");
  ones_b_a: assert property (
    (wr_csb && !st_ff.flg_b[2] && !eq_bb) |=> !st_ff.flg_b[2])
    else $error("match-b flag set by write");
  cap_flag_only_a: assert property (
    (!st_ff.flg_a[0] && !(st_ff.cap == CAP_FALL && ext_fall)) |=> !st_ff.flg_a[0])
    else $error("capture flag set without a rise and fall");
  irq_off_a: assert property (
    !st_ff.ctl_b[`TSCC_BIT_B4] |=> !CAPTURE_IRQ_REQUEST)
    else $error("capture request while disabled");
  fall_cap_a: assert property (
    (st_ff.cap == CAP_FALL && ext_fall) |=> (st_ff.fall == $past(CHAN_A_COUNTER[7:0])))
    else $error("falling capture wrong");
  cap_regs_hold_a: assert property (
    !cap_ld |=> ($stable(st_ff.rise) && $stable(st_ff.fall)))
    else $error("capture register changed without a capture");
  start_set_only_a: assert property (
    (!st_ff.start && !(wr_conn && WDATA[`TSCC_BIT_START] && st_ff.arm_start)) |=>
    !st_ff.start)
    else $error("start bit set without read of zero");
  tcc_load_a: assert property (wr_tcc |=> (st_ff.tcc == $past(WDATA)))
    else $error("time constant not loaded");
  tcc_hold_a: assert property (!wr_tcc |=> $stable(st_ff.tcc))
    else $error("time constant changed without a write");
  cap_blind_a: assert property (cap_ld |=> !MATCH_C)
    else $error("match c during capture load");
  rdata_idle_a: assert property (!RD |=> (RDATA == 8'h00))
    else $error("read data outside its cycle");
endmodule // tscc_top

// ==== pkg/tscc_map.svh ====
`ifndef TSCC_MAP_SVH
`define TSCC_MAP_SVH
// register indices on the plain port
`define TSCC_OFS_CS_B 3'h0
`define TSCC_OFS_CS_A 3'h1
`define TSCC_OFS_TCC 3'h2
`define TSCC_OFS_RISE 3'h3
`define TSCC_OFS_FALL 3'h4
`define TSCC_OFS_CONN 3'h5
// status/control bit positions
`define TSCC_BIT_MFB 7
`define TSCC_BIT_MFA 6
`define TSCC_BIT_WRAP 5
`define TSCC_BIT_B4 4
`define TSCC_BIT_START 4
// reset values
`define TSCC_RST_TCC 8'hff
`define TSCC_RST_CAP 8'h00
`define TSCC_RST_CNT 8'hff
// output action codes
`define TSCC_ACT_KEEP 2'h0
`define TSCC_ACT_LOW 2'h1
`define TSCC_ACT_HIGH 2'h2
`define TSCC_ACT_TOG 2'h3
`endif

// ==== pkg/tscc_pkg.sv ====
`include "tscc_map.svh"
package tscc_pkg;
  typedef enum logic [1:0] {CAP_IDLE, CAP_RISE, CAP_FALL} tscc_cap_t;

  typedef struct packed {
    logic [2:0] flg_b;
    logic [2:0] arm_b;
    logic [4:0] ctl_b;
    logic [3:0] flg_a;
    logic [3:0] arm_a;
    logic [3:0] ctl_a;
    logic [7:0] tcc;
    logic [7:0] rise;
    logic [7:0] fall;
    logic start;
    logic arm_start;
    tscc_cap_t cap;
    logic [7:0] prev_a;
    logic [7:0] prev_b;
    logic [3:0] eq_prev;
    logic match_c;
    logic irq;
    logic [7:0] rdata;
  } tscc_top_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tscc_sync_st_t;

  typedef struct packed {
    logic pin;
  } tscc_pin_st_t;

  function automatic logic tscc_act(logic pin, logic [1:0] act);
    unique case (act)
      `TSCC_ACT_KEEP: return pin;
      `TSCC_ACT_LOW: return 1'b0;
      `TSCC_ACT_HIGH: return 1'b1;
      `TSCC_ACT_TOG: return ~pin;
    endcase
  endfunction
endpackage
